// ---- hw/stored_step_program_sequencer.sv ----
/*
  Stored step program sequencer: front panel step editing and
  execution of stored program steps onto the active parameter set.
  Assumes keys and overload come from pins, edit data and run start
  from panel logic on CLOCK.
*/
// How it works
// - storage holds 99 steps, selected by two-digit step number
// - step records survive power loss in nonvolatile storage
// - record holds command, count, timer and the full parameter set
// - code 0 loads repeat counter and moves to next step
// - code 1 applies parameters, waits timer, then jumps to target
// - code 2 as code 1 but decrements repeat counter at end
// - after decrement, nonzero counter jumps, zero goes to next step
// - code 3 adds step setpoint per interval, count times, then next
// - codes 3 and 4 load all parameters except setpoint at start
// - code 4 subtracts step setpoint per interval, then next step
// - code 5 moves setpoint one unit per interval toward target
// - code 5 also ramps gain, rate, reset; jumps when all arrive
// - code 8 jumps to target keeping current parameters
// - code 9 ends program and installs its parameters
// - count up to 99, timer up to 30 days in d/h/m/s
// - program key flashes indicator, internal key enters edit mode
// - entering edit mode always selects step 01
// - displays show step/cmd/count, days/hours, minutes/seconds
// - scan key writes the edited step into storage
// - program key in edit mode leaves edit and clears indicator
// - input overload forces heater range off
// - leaving a step without scan discards edits
`default_nettype none
`include "seq_regs.svh"

module stored_step_program_sequencer
  import seq_pkg::*;
#(
  parameter int TICKS_PER_SEC = `TICKS_PER_SEC
) (
  input wire logic CLOCK, // 20 MHz system clock
  input wire logic RESETN, // asynchronous reset, active low
  input wire logic KEY_PROGRAM_EDIT_KEY, // program_edit_key pin, high pressed
  input wire logic KEY_INT, // internal key pin
  input wire logic KEY_SCAN, // scan key pin
  input wire logic KEY_CLEAR, // clear key pin
  input wire logic KEY_UP, // step up key pin
  input wire logic KEY_DOWN, // step down key pin
  input wire logic INPUT_OVERLOAD, // input_overload pin, high active
  input wire logic EDIT_WE, // pulse: load EDIT_REC into edit copy
  input wire step_rec_t EDIT_REC, // edited record from panel
  input wire logic STEP_SEL_WE, // pulse: select STEP_SEL for editing
  input wire logic [6:0] STEP_SEL, // step picked by number entry
  input wire logic FRONT_WE, // pulse: load front panel values
  input wire params_t FRONT_PARAMS, // front panel values
  input wire logic RUN_START, // pulse: start program
  input wire logic [6:0] START_STEP, // first step to run
  output params_t PARAMS, // active control parameters
  output logic RUNNING, // program executing
  output logic PROGRAM_EDIT_KEY_LED, // program indicator
  output logic INT_LED, // internal indicator
  output upper_disp_t UPPER_DISP, // step, command, count
  output logic [9:0] MID_DISP, // days, hours
  output logic [11:0] LOW_DISP // minutes, seconds
);

  localparam int NKEY = 7;
  localparam int K_PROGRAM_EDIT_KEY = 0;
  localparam int K_INT = 1;
  localparam int K_SCAN = 2;
  localparam int K_CLEAR = 3;
  localparam int K_UP = 4;
  localparam int K_DOWN = 5;
  localparam int K_OVL = 6;

  // ----------------------------------------------------------------
  // pin synchronisers and press detection
  // ----------------------------------------------------------------
  logic [NKEY-1:0] pin_raw;
  logic [NKEY-1:0] s1_q, s2_q, s3_q, level_q, press_q;

  assign pin_raw = {INPUT_OVERLOAD, KEY_DOWN, KEY_UP, KEY_CLEAR,
                    KEY_SCAN, KEY_INT, KEY_PROGRAM_EDIT_KEY};

  genvar gi;
  generate
    for (gi = 0; gi < NKEY; gi++) begin : g_sync
      always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          level_q[gi] <= 1'b0;
          press_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          press_q[gi] <= 1'b0;
          // change counts only when the two later stages agree
          if (s2_q[gi] == s3_q[gi]) begin
            level_q[gi] <= s2_q[gi];
            press_q[gi] <= s2_q[gi] & ~level_q[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // seconds timebase
  // ----------------------------------------------------------------
  logic [24:0] div_q;
  logic tick_q, flash_q;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      div_q <= '0;
      tick_q <= 1'b0;
      flash_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (div_q == 25'(TICKS_PER_SEC - 1)) begin
        div_q <= '0;
        tick_q <= 1'b1;
        flash_q <= ~flash_q;
      end else begin
        div_q <= div_q + 25'h000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [21:0] secs(input timer_t t);
    secs = 22'(t.days) * `SEC_PER_DAY + 22'(t.hours) * `SEC_PER_HOUR
         + 22'(t.minutes) * `SEC_PER_MIN + 22'(t.seconds);
  endfunction

  function automatic logic [15:0] toward(input logic [15:0] cur,
                                         input logic [15:0] tgt);
    if (cur < tgt) toward = cur + 16'h0001;
    else if (cur > tgt) toward = cur - 16'h0001;
    else toward = cur;
  endfunction

  function automatic logic step_ok(input logic [6:0] s);
    step_ok = (s >= `STEP_FIRST) && (s <= `STEP_LAST);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  exec_state_t xst_q;
  edit_state_t est_q;
  logic [6:0] run_step_q, edit_step_q, rep_q, ramp_left_q;
  logic [21:0] ivl_q;
  step_rec_t cur_q, edit_q, rd_data;
  params_t active_q;
  logic eld_q, eld2_q;

  logic in_exec, ivl_done, editing, mem_we;
  logic [6:0] rd_addr, next_step;
  logic [15:0] nxt_sp, nxt_gain, nxt_rate, nxt_reset;
  logic ramp_all_done;
  step_rec_t rec;

  assign editing = (est_q == E_EDIT);
  assign rd_addr = editing ? edit_step_q : run_step_q;
  assign mem_we = editing & press_q[K_SCAN] & ~eld_q & ~eld2_q;
  assign in_exec = (xst_q == X_EXEC);
  assign rec = rd_data;
  assign ivl_done = (xst_q == X_WAIT) && (ivl_q == `IVL_RST);
  assign next_step = run_step_q + 7'h01;

  step_store u_store (
    .clk(CLOCK),
    .we(mem_we),
    .waddr(edit_step_q),
    .wdata(edit_q),
    .raddr(rd_addr),
    .rdata(rd_data)
  );

  // code 5 ramp: next values one unit toward this step's targets
  assign nxt_sp = toward(active_q.setpoint, cur_q.params.setpoint);
  assign nxt_gain = toward({8'h00, active_q.gain},
                           {8'h00, cur_q.params.gain});
  assign nxt_rate = toward({8'h00, active_q.rate},
                           {8'h00, cur_q.params.rate});
  assign nxt_reset = toward({8'h00, active_q.reset},
                            {8'h00, cur_q.params.reset});
  assign ramp_all_done = (nxt_sp == cur_q.params.setpoint)
    && (nxt_gain[7:0] == cur_q.params.gain)
    && (nxt_rate[7:0] == cur_q.params.rate)
    && (nxt_reset[7:0] == cur_q.params.reset);

  // ----------------------------------------------------------------
  // execution sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      xst_q <= X_IDLE;
      run_step_q <= `STEP_FIRST;
      rep_q <= `COUNT_RST;
      ramp_left_q <= `COUNT_RST;
      ivl_q <= `IVL_RST;
      cur_q <= '0;
    end else if (xst_q != X_IDLE && press_q[K_CLEAR]) begin
      xst_q <= X_IDLE;
    end else begin
      case (xst_q)
        X_IDLE: begin
          if (RUN_START && est_q == E_NORM && step_ok(START_STEP)) begin
            run_step_q <= START_STEP;
            xst_q <= X_READ;
          end
        end
        X_READ: begin
          xst_q <= X_EXEC;
        end
        X_EXEC: begin
          cur_q <= rec;
          ivl_q <= secs(rec.timer);
          ramp_left_q <= rec.count;
          xst_q <= X_READ;
          case (rec.cmd)
            CMD_NULL: begin
              rep_q <= rec.count;
              run_step_q <= next_step;
              if (!step_ok(next_step)) xst_q <= X_IDLE;
            end
            CMD_DWELL, CMD_CDWELL: begin
              xst_q <= X_WAIT;
            end
            CMD_RAMP_UP, CMD_RAMP_DN: begin
              // zero ramp count has nothing to do
              if (rec.count != `COUNT_RST) begin
                xst_q <= X_WAIT;
              end else begin
                run_step_q <= next_step;
                if (!step_ok(next_step)) xst_q <= X_IDLE;
              end
            end
            CMD_RAMP_ALL: begin
              xst_q <= X_WAIT;
            end
            CMD_JUMP: begin
              run_step_q <= rec.count;
              if (!step_ok(rec.count)) xst_q <= X_IDLE;
            end
            CMD_EXIT: begin
              xst_q <= X_IDLE;
            end
            default: begin
              run_step_q <= next_step;
              if (!step_ok(next_step)) xst_q <= X_IDLE;
            end
          endcase
        end
        X_WAIT: begin
          if (ivl_done) begin
            ivl_q <= secs(cur_q.timer);
            case (cur_q.cmd)
              CMD_DWELL: begin
                run_step_q <= cur_q.count;
                xst_q <= step_ok(cur_q.count) ? X_READ : X_IDLE;
              end
              CMD_CDWELL: begin
                rep_q <= (rep_q == `COUNT_RST) ? rep_q
                       : rep_q - 7'h01;
                if (rep_q > 7'h01) begin
                  run_step_q <= cur_q.count;
                  xst_q <= step_ok(cur_q.count) ? X_READ : X_IDLE;
                end else begin
                  run_step_q <= next_step;
                  xst_q <= step_ok(next_step) ? X_READ : X_IDLE;
                end
              end
              CMD_RAMP_UP, CMD_RAMP_DN: begin
                ramp_left_q <= ramp_left_q - 7'h01;
                if (ramp_left_q == 7'h01) begin
                  run_step_q <= next_step;
                  xst_q <= step_ok(next_step) ? X_READ : X_IDLE;
                end
              end
              CMD_RAMP_ALL: begin
                if (ramp_all_done) begin
                  run_step_q <= cur_q.count;
                  xst_q <= step_ok(cur_q.count) ? X_READ : X_IDLE;
                end
              end
              default: begin
                xst_q <= X_IDLE;
              end
            endcase
          end else if (tick_q) begin
            ivl_q <= ivl_q - 22'h00_0001;
          end
        end
        default: begin
          xst_q <= X_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // active parameter set
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      active_q <= '0;
    end else if (in_exec) begin
      case (rec.cmd)
        CMD_DWELL, CMD_CDWELL, CMD_EXIT: begin
          active_q <= rec.params;
        end
        CMD_RAMP_UP, CMD_RAMP_DN, CMD_RAMP_ALL: begin
          // setpoint carries over from the previous step
          active_q <= rec.params;
          active_q.setpoint <= active_q.setpoint;
          if (rec.cmd == CMD_RAMP_ALL) begin
            active_q.gain <= active_q.gain;
            active_q.rate <= active_q.rate;
            active_q.reset <= active_q.reset;
          end
        end
        default: begin
          active_q <= active_q;
        end
      endcase
    end else if (ivl_done && xst_q == X_WAIT) begin
      case (cur_q.cmd)
        CMD_RAMP_UP: begin
          active_q.setpoint <= active_q.setpoint
                             + cur_q.params.setpoint;
        end
        CMD_RAMP_DN: begin
          active_q.setpoint <= active_q.setpoint
                             - cur_q.params.setpoint;
        end
        CMD_RAMP_ALL: begin
          active_q.setpoint <= nxt_sp;
          active_q.gain <= nxt_gain[7:0];
          active_q.rate <= nxt_rate[7:0];
          active_q.reset <= nxt_reset[7:0];
        end
        default: begin
          active_q <= active_q;
        end
      endcase
    end else if (FRONT_WE && xst_q == X_IDLE) begin
      active_q <= FRONT_PARAMS;
    end
  end

  // ----------------------------------------------------------------
  // step edit mode
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      est_q <= E_NORM;
      edit_step_q <= `STEP_FIRST;
      edit_q <= '0;
      eld_q <= 1'b0;
      eld2_q <= 1'b0;
    end else begin
      eld_q <= 1'b0;
      eld2_q <= eld_q;
      // read data trail the step number by one edge
      if (eld2_q) edit_q <= rd_data;
      case (est_q)
        E_NORM: begin
          if (press_q[K_PROGRAM_EDIT_KEY] && xst_q == X_IDLE) est_q <= E_ARM;
        end
        E_ARM: begin
          if (press_q[K_INT]) begin
            est_q <= E_EDIT;
            edit_step_q <= `STEP_FIRST;
            eld_q <= 1'b1;
          end else if (press_q[K_PROGRAM_EDIT_KEY]) begin
            est_q <= E_NORM;
          end
        end
        E_EDIT: begin
          // a step change reloads from storage, dropping edits
          if (press_q[K_PROGRAM_EDIT_KEY]) begin
            est_q <= E_NORM;
          end else if (STEP_SEL_WE && step_ok(STEP_SEL)) begin
            edit_step_q <= STEP_SEL;
            eld_q <= 1'b1;
          end else if (press_q[K_UP] && edit_step_q != `STEP_LAST) begin
            edit_step_q <= edit_step_q + 7'h01;
            eld_q <= 1'b1;
          end else if (press_q[K_DOWN]
                       && edit_step_q != `STEP_FIRST) begin
            edit_step_q <= edit_step_q - 7'h01;
            eld_q <= 1'b1;
          end else if (EDIT_WE && !eld_q && !eld2_q) begin
            edit_q <= EDIT_REC;
          end
        end
        default: begin
          est_q <= E_NORM;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      PARAMS <= '0;
      RUNNING <= 1'b0;
      PROGRAM_EDIT_KEY_LED <= 1'b0;
      INT_LED <= 1'b0;
      UPPER_DISP <= '0;
      MID_DISP <= '0;
      LOW_DISP <= '0;
    end else begin
      PARAMS <= active_q;
      if (level_q[K_OVL]) begin
        PARAMS.heater_range <= `HEATER_OFF;
      end
      RUNNING <= (xst_q != X_IDLE);
      PROGRAM_EDIT_KEY_LED <= (est_q == E_ARM) ? flash_q : editing;
      INT_LED <= editing | (xst_q != X_IDLE);
      UPPER_DISP <= '{step: edit_step_q, cmd: edit_q.cmd,
                      count: edit_q.count};
      MID_DISP <= {edit_q.timer.days, edit_q.timer.hours};
      LOW_DISP <= {edit_q.timer.minutes, edit_q.timer.seconds};
    end
  end

endmodule

`default_nettype wire

// ---- hw/seq_regs.svh ----
/*
  Constants of the stored step program sequencer: step range, timer
  scaling, timebase and reset values. Included by the sequencer and
  the step store modules; holds definitions only.
*/
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH

// ----------------------------------------------------------------
// step numbering
// ----------------------------------------------------------------
`define STEP_FIRST 7'h01
`define STEP_LAST 7'h63
`define STEP_DEPTH 100

// ----------------------------------------------------------------
// timebase
// ----------------------------------------------------------------
`define SEC_NS 1000000000
`define CLK_PERIOD_NS 50
`define TICKS_PER_SEC (`SEC_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// timer field scaling, in seconds
// ----------------------------------------------------------------
`define SEC_PER_MIN 22'h00_003C
`define SEC_PER_HOUR 22'h00_0E10
`define SEC_PER_DAY 22'h01_5180

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HEATER_OFF 3'h0
`define COUNT_RST 7'h00
`define IVL_RST 22'h00_0000

`endif

// ---- hw/seq_pkg.sv ----
/*
  Types of the stored step program sequencer: step record, parameter
  set, timer, display groups and state encodings.
  Assumes seq_regs.svh is on the include path.
*/
`default_nettype none

package seq_pkg;

  typedef enum logic [3:0] {
    CMD_NULL = 4'b0000,
    CMD_DWELL = 4'b0001,
    CMD_CDWELL = 4'b0010,
    CMD_RAMP_UP = 4'b0011,
    CMD_RAMP_DN = 4'b0100,
    CMD_RAMP_ALL = 4'b0101,
    CMD_JUMP = 4'b1000,
    CMD_EXIT = 4'b1001
  } cmd_t;

  typedef struct packed {
    logic [4:0] days;
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
  } timer_t;

  typedef struct packed {
    logic [1:0] sensors;
    logic [3:0] units;
    logic [1:0] resolution;
    logic [15:0] setpoint;
    logic [7:0] gain;
    logic [7:0] rate;
    logic [7:0] reset;
    logic [7:0] heater_power;
    logic [2:0] heater_range;
    logic [1:0] filtering;
  } params_t;

  typedef struct packed {
    logic [3:0] cmd;
    logic [6:0] count;
    timer_t timer;
    params_t params;
  } step_rec_t;

  typedef struct packed {
    logic [6:0] step;
    logic [3:0] cmd;
    logic [6:0] count;
  } upper_disp_t;

  typedef enum logic [2:0] {
    X_IDLE = 3'b000,
    X_READ = 3'b001,
    X_EXEC = 3'b010,
    X_WAIT = 3'b011
  } exec_state_t;

  typedef enum logic [1:0] {
    E_NORM = 2'b00,
    E_ARM = 2'b01,
    E_EDIT = 2'b10
  } edit_state_t;

endpackage

`default_nettype wire

// ---- hw/step_store.sv ----
/*
  Program step storage: one write port, one read port whose data
  come out of a register. Assumes a single clock; the array has no
  reset so that its contents outlive a reset, standing in for the
  nonvolatile part.
*/
`default_nettype none
`include "seq_regs.svh"

module step_store
  import seq_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic we, // write strobe
  input wire logic [6:0] waddr, // write step number
  input wire step_rec_t wdata, // record to store
  input wire logic [6:0] raddr, // read step number
  output step_rec_t rdata // registered read data
);

  step_rec_t mem [`STEP_DEPTH];

  // no reset: contents are retained across reset and power cycles
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

// ---- verification/seq_props.sv ----
/*
  Port checker of the stored step program sequencer.
  Assumes it is bound to the top module, CLOCK rising, RESETN low reset.
*/
`default_nettype none

module seq_props
  import seq_pkg::*;
#(
  parameter int TICKS_PER_SEC = 4
) (
  input wire logic CLOCK, // system clock
  input wire logic RESETN, // reset, active low
  input wire logic KEY_PROGRAM_EDIT_KEY, // program_edit_key pin
  input wire logic KEY_CLEAR, // clear key pin
  input wire logic INPUT_OVERLOAD, // input_overload pin
  input wire logic FRONT_WE, // front value load
  input wire params_t FRONT_PARAMS, // front values
  input wire logic RUN_START, // run start pulse
  input wire params_t PARAMS, // active parameters
  input wire logic RUNNING, // program executing
  input wire logic PROGRAM_EDIT_KEY_LED, // program indicator
  input wire logic INT_LED, // internal indicator
  input wire upper_disp_t UPPER_DISP // upper display
);
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  sequence s_edit;
    INT_LED && PROGRAM_EDIT_KEY_LED && !RUNNING;
  endsequence
  sequence s_leds_off;
    !PROGRAM_EDIT_KEY_LED && !INT_LED;
  endsequence
  // six samples cover the three-stage sync, the level register and the output register
  sequence s_ovl_held;
    INPUT_OVERLOAD [*6];
  endsequence

  a_ovl_heater_off: assert property (s_ovl_held |->
    PARAMS.heater_range == 3'h0) else $error("heater not off");
  a_run_needs_start: assert property ($rose(RUNNING) |->
    $past(RUN_START) || $past(RUN_START, 2) || $past(RUN_START, 3))
    else $error("run without start");
  a_run_int_led: assert property ($rose(RUNNING) |->
    ##[0:2] INT_LED) else $error("internal led dark in run");
  a_edit_step_one: assert property ($rose(INT_LED) && !RUNNING |->
    ##[0:3] (UPPER_DISP.step == 7'h01 || RUNNING))
    else $error("edit entry not at step one");
  a_program_edit_key_exit_edit: assert property (s_edit ##0 $rose(KEY_PROGRAM_EDIT_KEY) |->
    ##[1:8] s_leds_off) else $error("edit not left");
  a_clear_stops: assert property ($rose(KEY_CLEAR) && RUNNING |->
    ##[1:8] !RUNNING) else $error("clear did not stop");
  a_front_load: assert property (!INPUT_OVERLOAD [*5] ##0
    (FRONT_WE && !RUNNING) |-> ##[1:2] PARAMS == FRONT_PARAMS)
    else $error("front values not loaded");
  a_run_excl_edit: assert property (PROGRAM_EDIT_KEY_LED |-> !RUNNING)
    else $error("run during edit");
endmodule

`default_nettype wire

// ---- verification/panel_model.sv ----
/*
  Front panel keypad model: presses one key at a time.
  Assumes keys are synchronised by the design on clk.
*/
`default_nettype none

module panel_model (
  input wire logic clk, // system clock
  output logic [5:0] keys // program_edit_key, int, scan, clear, up, down
);
  // ----------------------------------------------------------------
  // key presses
  // ----------------------------------------------------------------
  initial keys = 6'h00;
  // held six cycles so the sync counts exactly one press
  task automatic press(input int k);
    @(negedge clk);
    keys[k] = 1'b1;
    repeat (6) @(negedge clk);
    keys[k] = 1'b0;
    repeat (6) @(negedge clk);
  endtask
endmodule

`default_nettype wire

// ---- verification/testbench.sv ----
/*
  Self-checking bench: edits steps through the panel model, runs them
  and compares with integer expectations. Assumes the package, design,
  checker and panel model are compiled first.
*/
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  bad_count++; $display("Error t=%0t got %h exp %h", $time, g, e); end end

module testbench;
  import seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TPS = 4;
  localparam int KP = 0, KI = 1, KS = 2, KC = 3, KU = 4, KD = 5;
  logic clock, resetn, ovl, edit_we, sel_we, front_we, run_start;
  logic running, program_edit_key_led, int_led;
  logic [5:0] keys;
  logic [6:0] step_sel, start_step;
  logic [9:0] mid;
  logic [11:0] low;
  step_rec_t edit_rec;
  params_t front, params, exp_p;
  upper_disp_t upper;
  step_rec_t program_edit_key [1:11];
  int bad_count, samples_checked, sp;

  panel_model pnl (.clk(clock), .keys(keys));
  stored_step_program_sequencer #(.TICKS_PER_SEC(TPS)) DUT (
    .CLOCK(clock), .RESETN(resetn), .KEY_PROGRAM_EDIT_KEY(keys[0]), .KEY_INT(keys[1]),
    .KEY_SCAN(keys[2]), .KEY_CLEAR(keys[3]), .KEY_UP(keys[4]),
    .KEY_DOWN(keys[5]), .INPUT_OVERLOAD(ovl), .EDIT_WE(edit_we),
    .EDIT_REC(edit_rec), .STEP_SEL_WE(sel_we), .STEP_SEL(step_sel),
    .FRONT_WE(front_we), .FRONT_PARAMS(front), .RUN_START(run_start),
    .START_STEP(start_step), .PARAMS(params), .RUNNING(running),
    .PROGRAM_EDIT_KEY_LED(program_edit_key_led), .INT_LED(int_led), .UPPER_DISP(upper),
    .MID_DISP(mid), .LOW_DISP(low));

  // ----------------------------------------------------------------
  // clock, closing and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // whole run is under 1000 cycles; 20000 leaves ample margin
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  function automatic step_rec_t mk(input int c, input int n);
    step_rec_t r;
    logic [63:0] w;
    w = {$urandom, $urandom};
    r.params = w[60:0];
    r.cmd = 4'(c);
    r.count = 7'(n);
    r.timer = 22'h00_0001;
    return r;
  endfunction
  task automatic sel(input int n);
    @(negedge clock);
    step_sel = 7'(n);
    sel_we = 1'b1;
    @(negedge clock);
    sel_we = 1'b0;
    cyc(4);
  endtask
  // a reload is pending right after a select, hence the wait in sel
  task automatic put(input int n, input step_rec_t r, input bit scan);
    sel(n);
    edit_rec = r;
    edit_we = 1'b1;
    @(negedge clock);
    edit_we = 1'b0;
    if (scan) pnl.press(KS);
    cyc(3);
  endtask
  task automatic show(input int n, input step_rec_t r);
    `CHK(upper, {7'(n), r.cmd, r.count})
    `CHK(mid, {r.timer.days, r.timer.hours})
    `CHK(low, {r.timer.minutes, r.timer.seconds})
  endtask
  task automatic run(input int s, input int w);
    int i;
    @(negedge clock);
    start_step = 7'(s);
    run_start = 1'b1;
    @(negedge clock);
    run_start = 1'b0;
    cyc(3);
    `CHK(running, 1'b1)
    for (i = 0; i < w && running; i++) @(negedge clock);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {resetn, ovl, edit_we, sel_we, front_we, run_start} = 6'h00;
    {step_sel, start_step, edit_rec, front} = '0;
    void'($urandom(91));
    cyc(5);
    `CHK({running, program_edit_key_led, int_led}, 3'h0)
    resetn = 1'b1;
    program_edit_key[1] = mk(0, 2);
    program_edit_key[2] = mk(2, 2);
    program_edit_key[3] = mk(3, 2);
    program_edit_key[4] = mk(8, 6);
    program_edit_key[5] = mk(1, 5);
    program_edit_key[6] = mk(4, 1);
    program_edit_key[7] = mk(6, 0);
    program_edit_key[8] = mk(8, 0);
    program_edit_key[9] = mk(1, 10);
    program_edit_key[10] = mk(9, 0);
    program_edit_key[11] = mk(1, 11);
    program_edit_key[11].timer = 22'h00_0040;
    cyc(3);
    pnl.press(KP);
    pnl.press(KI);
    `CHK({program_edit_key_led, int_led}, 2'h3)
    `CHK(upper.step, 7'h01)
    for (int n = 1; n <= 11; n++) put(n, program_edit_key[n], 1'b1);
    put(5, mk(5, 3), 1'b0);
    sel(6);
    for (int n = 1; n <= 11; n++) begin
      sel(n);
      show(n, program_edit_key[n]);
    end
    sel(99);
    pnl.press(KU);
    `CHK(upper.step, 7'h63)
    pnl.press(KD);
    `CHK(upper.step, 7'h62)
    pnl.press(KP);
    `CHK({program_edit_key_led, int_led}, 2'h0)
    run(1, 3000);
    sp = program_edit_key[2].params.setpoint + 2 * program_edit_key[3].params.setpoint;
    sp = sp - program_edit_key[6].params.setpoint;
    exp_p = program_edit_key[6].params;
    exp_p.setpoint = 16'(sp);
    `CHK(params, exp_p)
    `CHK(running, 1'b0)
    run(9, 500);
    `CHK(params, program_edit_key[10].params)
    `CHK(running, 1'b0)
    run(11, 30);
    `CHK(params, program_edit_key[11].params)
    pnl.press(KC);
    `CHK(running, 1'b0)
    ovl = 1'b1;
    cyc(8);
    `CHK(params.heater_range, 3'h0)
    ovl = 1'b0;
    cyc(8);
    `CHK(params, program_edit_key[11].params)
    edit_rec = mk(0, 0);
    front = edit_rec.params;
    front_we = 1'b1;
    @(negedge clock);
    front_we = 1'b0;
    cyc(2);
    `CHK(params, front)
    // code 5 from the front values: a few units each way, then stop
    edit_rec.cmd = 4'h5;
    edit_rec.params.setpoint = front.setpoint ^ 16'h0003;
    edit_rec.params.gain = front.gain ^ 8'h05;
    pnl.press(KP);
    pnl.press(KI);
    put(12, edit_rec, 1'b1);
    pnl.press(KP);
    run(12, 300);
    `CHK(params, edit_rec.params)
    `CHK(running, 1'b0)
    test_done();
  end
endmodule

bind stored_step_program_sequencer seq_props #(
  .TICKS_PER_SEC(TICKS_PER_SEC)) u_props (.CLOCK(CLOCK), .RESETN(RESETN),
  .KEY_PROGRAM_EDIT_KEY(KEY_PROGRAM_EDIT_KEY), .KEY_CLEAR(KEY_CLEAR),
  .INPUT_OVERLOAD(INPUT_OVERLOAD), .FRONT_WE(FRONT_WE),
  .FRONT_PARAMS(FRONT_PARAMS), .RUN_START(RUN_START), .PARAMS(PARAMS),
  .RUNNING(RUNNING), .PROGRAM_EDIT_KEY_LED(PROGRAM_EDIT_KEY_LED), .INT_LED(INT_LED),
  .UPPER_DISP(UPPER_DISP));

`default_nettype wire
